// *** hdl/eccs_pkg.sv ***
// Package: register map, fields and encodings of the ECC control block
package eccs_pkg;
   // ==================================================
   // Register byte offsets
   localparam logic [8:0] ECCS_OFF_CTRL   = 9'h000;
   localparam logic [8:0] ECCS_OFF_MODE   = 9'h004;
   localparam logic [8:0] ECCS_OFF_STAT   = 9'h008;
   localparam logic [8:0] ECCS_OFF_PAR0   = 9'h00c;
   localparam logic [8:0] ECCS_OFF_PAR1   = 9'h010;
   localparam logic [8:0] ECCS_OFF_SYND   = 9'h050;
   localparam int         ECCS_ADDR_W     = 9;
   // ==================================================
   // Field positions
   localparam int ECCS_CTRL_CLR_BIT  = 0;
   localparam int ECCS_MODE_CORR_BIT = 10;
   localparam int ECCS_MODE_HALT_BIT = 8;
   localparam int ECCS_MODE_TYPE_LSB = 4;
   localparam int ECCS_MODE_PAGE_LSB = 0;
   localparam logic [31:0] ECCS_MODE_MASK = 32'h0000_0577;
   localparam logic [31:0] ECCS_RST_VAL   = 32'h0000_0000;
   localparam int ECCS_NSEC           = 8;
   // ==================================================
   // Correction type codes
   localparam logic [2:0] ECCS_TYPE_PAGE = 3'h0;
   localparam logic [2:0] ECCS_TYPE_S256 = 3'h1;
   localparam logic [2:0] ECCS_TYPE_S512 = 3'h2;
   localparam logic [2:0] ECCS_TYPE_RS   = 3'h4;
   // Page length in words, hamming codes 0..3
   localparam logic [12:0] ECCS_PAGE_W0 = 13'h0210;
   localparam logic [12:0] ECCS_PAGE_W1 = 13'h0420;
   localparam logic [12:0] ECCS_PAGE_W2 = 13'h0840;
   localparam logic [12:0] ECCS_PAGE_W3 = 13'h1080;
   localparam logic [12:0] ECCS_RS_SECT = 13'h0210;
   localparam logic [12:0] ECCS_S256    = 13'h0100;
   localparam logic [12:0] ECCS_S512    = 13'h0200;
   // AXI responses
   localparam logic [1:0] ECCS_RESP_OK  = 2'h0;
   localparam logic [1:0] ECCS_RESP_ERR = 2'h2;
   typedef enum logic [3:0] {
      ECCS_IDLE = 4'b0001,
      ECCS_RUN  = 4'b0010,
      ECCS_CORR = 4'b0100,
      ECCS_DONE = 4'b1000
   } eccs_state_t;
endpackage

// *** hdl/eccs_sector_check.sv ***
// Per-sector error classifier: hamming syndrome or RS zero test
`timescale 1ns/1ps
module eccs_sector_check
   import eccs_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Evaluation request
   input  wire logic        eval,
   input  wire logic        rs_mode,
   input  wire logic [15:0] ham_syndrome,
   input  wire logic [31:0] rs_syndrome,
   // Result
   output logic             res_valid,
   output logic             res_err,
   output logic             res_single,
   output logic             res_multi
);
   logic       valid_ff, err_ff, single_ff, multi_ff;
   logic       nxt_valid, nxt_err, nxt_single, nxt_multi;
   logic [7:0] line_x;
   logic [7:0] col_x;

   always_comb begin
      line_x     = ham_syndrome[15:8];
      col_x      = ham_syndrome[7:0];
      nxt_valid  = eval;
      nxt_err    = err_ff;
      nxt_single = single_ff;
      nxt_multi  = multi_ff;
      if (eval) begin
         if (rs_mode) begin
            // All syndromes zero means error free
            nxt_err    = |rs_syndrome; // RULE_19
            nxt_single = 1'b0;
            nxt_multi  = 1'b0;
         end else begin
            // A single flip inverts exactly one of each parity pair
            nxt_err    = |ham_syndrome; // RULE_16
            nxt_single = (line_x == ~col_x) || ($countones(ham_syndrome) == 1);
            nxt_multi  = (|ham_syndrome) && !nxt_single; // RULE_12
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         valid_ff  <= 1'b0;
         err_ff    <= 1'b0;
         single_ff <= 1'b0;
         multi_ff  <= 1'b0;
      end else begin
         valid_ff  <= nxt_valid;
         err_ff    <= nxt_err;
         single_ff <= nxt_single;
         multi_ff  <= nxt_multi;
      end
   end

   assign res_valid  = valid_ff;
   assign res_err    = err_ff;
   assign res_single = single_ff;
   assign res_multi  = multi_ff;
endmodule

// *** hdl/eccs_ctrl.sv ***
// Top: ECC control, mode and status with AXI4-Lite register access
// Operation
// RULE_01 - Writing one to parity clear resets parity results; reads zero
// RULE_02 - Correction enable set: continue to correction, interrupts permitted
// RULE_03 - Correction enable clear: stop after partial syndrome step
// RULE_04 - Halt bit set stops computation until software clears it
// RULE_05 - Halt clear: computation starts on a flash read or write command
// RULE_06 - Type 000 page, 001 256-byte, 010 512-byte hamming sectors
// RULE_07 - Type 100 selects four-error RS per 512 bytes; others reserved
// RULE_08 - Hamming page codes 0..3 give 528, 1056, 2112, 4224 words
// RULE_09 - Hamming word is 8 or 16 bits, as the flash bus
// RULE_10 - RS page codes 0..7 give one to eight 528-byte sectors
// RULE_11 - Hamming status nibble n: found, single, multi, zero
// RULE_12 - Multi-error flag set when more than one error in sector
// RULE_13 - Page mode uses sector 0 flags; sector modes use as many needed
// RULE_14 - Single-error flag set for exactly one bit error in sector
// RULE_15 - Page mode error location readable in parity registers 0 and 1
// RULE_16 - Found flag set on any error; with multi means uncorrected
// RULE_17 - RS status bit n set when sector n holds an error
// RULE_18 - Sector vector cleared on new flash command or parity reset
// RULE_19 - Zero RS syndromes mean error free, otherwise syndrome stored
// RULE_20 - Single error reports word and bit offset of corrupted bit
// RULE_21 - One clock; system reset clears all mode and status to zero
// RULE_22 - Software programs type and size while halted, before command
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module eccs_ctrl
   import eccs_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Flash command and data watch, same clock domain
   input  wire logic        flash_cmd,
   input  wire logic        flash_wide,
   input  wire logic        flash_data_valid,
   input  wire logic [15:0] flash_data,
   input  wire logic        sector_end,
   input  wire logic [15:0] ham_syndrome,
   input  wire logic [31:0] rs_syndrome,
   // Engine status
   output logic             compute_active,
   output logic             correct_start,
   output logic             irq_permit,
   output logic [12:0]      page_words
);
   // ==================================================
   // Register state
   logic [31:0] mode_ff, nxt_mode;
   logic [31:0] stat_ff, nxt_stat;
   logic [31:0] par0_ff, nxt_par0;
   logic [31:0] par1_ff, nxt_par1;
   logic [31:0] synd_ff, nxt_synd;
   logic [2:0]  sec_ff, nxt_sec;
   logic [12:0] wcnt_ff, nxt_wcnt;
   logic [12:0] pwords_ff, nxt_pwords;
   logic [15:0] hsyn_ff, nxt_hsyn;
   logic [31:0] rsyn_ff, nxt_rsyn;
   eccs_state_t st_ff, nxt_st;
   logic        act_ff, nxt_act, cst_ff, nxt_cst, irq_ff, nxt_irq;
   // Bus state
   logic        aw_ff, w_ff, bv_ff, rv_ff;
   logic        nxt_aw, nxt_w, nxt_bv, nxt_rv;
   logic        awrdy_ff, wrdy_ff, arrdy_ff;
   logic        nxt_awrdy, nxt_wrdy, nxt_arrdy;
   logic [8:0]  awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic [3:0]  ws_ff, nxt_ws;
   logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
   logic        wr_do, wr_hit, rd_hit, clr_par;
   logic [31:0] rd_val;
   // Checker results
   logic        chk_valid, chk_err, chk_single, chk_multi;
   logic [2:0]  typ;
   logic [2:0]  psz;
   logic        rs_mode;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i])
            res[i*8 +: 8] = data[i*8 +: 8];
      end
      return res;
   endfunction

   // Hamming page length in words, RS length in bytes
   function automatic logic [12:0] page_len(input logic       rs,
                                            input logic [2:0] code);
      logic [12:0] len;
      len = ECCS_PAGE_W0;
      if (rs) begin
         len = 13'((code + 4'h1) * ECCS_RS_SECT); // RULE_10
      end else begin
         unique case (code[1:0]) // RULE_08
            2'h0: len = ECCS_PAGE_W0;
            2'h1: len = ECCS_PAGE_W1;
            2'h2: len = ECCS_PAGE_W2;
            2'h3: len = ECCS_PAGE_W3;
         endcase
      end
      return len;
   endfunction

   assign typ     = mode_ff[ECCS_MODE_TYPE_LSB +: 3];
   assign psz     = mode_ff[ECCS_MODE_PAGE_LSB +: 3];
   assign rs_mode = (typ == ECCS_TYPE_RS); // RULE_07

   // ==================================================
   // Sector checker
   eccs_sector_check u_check (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .eval         (sector_end && act_ff),
      .rs_mode      (rs_mode),
      .ham_syndrome (ham_syndrome),
      .rs_syndrome  (rs_syndrome),
      .res_valid    (chk_valid),
      .res_err      (chk_err),
      .res_single   (chk_single),
      .res_multi    (chk_multi)
   );

   // ==================================================
   // AXI4-Lite slave
   always_comb begin
      nxt_aw  = aw_ff;
      nxt_w   = w_ff;
      nxt_bv  = bv_ff;
      nxt_rv  = rv_ff;
      nxt_awa = awa_ff;
      nxt_wd  = wd_ff;
      nxt_ws  = ws_ff;
      nxt_br  = br_ff;
      nxt_rr  = rr_ff;
      nxt_rd  = rd_ff;
      rd_val  = 32'h0000_0000;
      if (s_axi_awvalid && awrdy_ff) begin
         nxt_aw  = 1'b1;
         nxt_awa = s_axi_awaddr[ECCS_ADDR_W-1:0];
      end
      if (s_axi_wvalid && wrdy_ff) begin
         nxt_w  = 1'b1;
         nxt_wd = s_axi_wdata;
         nxt_ws = s_axi_wstrb;
      end
      wr_do  = aw_ff && w_ff && !bv_ff;
      wr_hit = (awa_ff == ECCS_OFF_CTRL) || (awa_ff == ECCS_OFF_MODE);
      if (wr_do) begin
         nxt_aw = 1'b0;
         nxt_w  = 1'b0;
         nxt_bv = 1'b1;
         nxt_br = wr_hit ? ECCS_RESP_OK : ECCS_RESP_ERR;
      end
      if (bv_ff && s_axi_bready)
         nxt_bv = 1'b0;
      rd_hit = 1'b1;
      unique case (s_axi_araddr[ECCS_ADDR_W-1:0])
         ECCS_OFF_CTRL: rd_val = ECCS_RST_VAL; // RULE_01
         ECCS_OFF_MODE: rd_val = mode_ff;
         ECCS_OFF_STAT: rd_val = stat_ff;
         ECCS_OFF_PAR0: rd_val = par0_ff; // RULE_15
         ECCS_OFF_PAR1: rd_val = par1_ff;
         ECCS_OFF_SYND: rd_val = synd_ff;
         default:       rd_hit = 1'b0;
      endcase
      if (s_axi_arvalid && arrdy_ff) begin
         nxt_rv = 1'b1;
         nxt_rd = rd_val;
         nxt_rr = rd_hit ? ECCS_RESP_OK : ECCS_RESP_ERR;
      end else if (rv_ff && s_axi_rready) begin
         nxt_rv = 1'b0;
      end
      // Ready flags registered so every bus output leaves a flop
      nxt_awrdy = !nxt_aw && !nxt_bv;
      nxt_wrdy  = !nxt_w && !nxt_bv;
      nxt_arrdy = !nxt_rv;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff  <= 1'b0;
         w_ff   <= 1'b0;
         bv_ff  <= 1'b0;
         rv_ff  <= 1'b0;
         awa_ff <= '0;
         wd_ff  <= ECCS_RST_VAL;
         ws_ff  <= 4'h0;
         br_ff  <= ECCS_RESP_OK;
         rr_ff  <= ECCS_RESP_OK;
         rd_ff  <= ECCS_RST_VAL;
         awrdy_ff <= 1'b0;
         wrdy_ff  <= 1'b0;
         arrdy_ff <= 1'b0;
      end else begin
         aw_ff  <= nxt_aw;
         w_ff   <= nxt_w;
         bv_ff  <= nxt_bv;
         rv_ff  <= nxt_rv;
         awa_ff <= nxt_awa;
         wd_ff  <= nxt_wd;
         ws_ff  <= nxt_ws;
         br_ff  <= nxt_br;
         rr_ff  <= nxt_rr;
         rd_ff  <= nxt_rd;
         awrdy_ff <= nxt_awrdy;
         wrdy_ff  <= nxt_wrdy;
         arrdy_ff <= nxt_arrdy;
      end
   end

   assign s_axi_awready = awrdy_ff;
   assign s_axi_wready  = wrdy_ff;
   assign s_axi_bvalid  = bv_ff;
   assign s_axi_bresp   = br_ff;
   assign s_axi_arready = arrdy_ff;
   assign s_axi_rvalid  = rv_ff;
   assign s_axi_rdata   = rd_ff;
   assign s_axi_rresp   = rr_ff;

   // ==================================================
   // Mode, sequencing and status
   assign clr_par = wr_do && (awa_ff == ECCS_OFF_CTRL) && ws_ff[0]
                    && wd_ff[ECCS_CTRL_CLR_BIT]; // RULE_01

   always_comb begin
      nxt_mode     = mode_ff;
      nxt_stat     = stat_ff;
      nxt_par0     = par0_ff;
      nxt_par1     = par1_ff;
      nxt_synd     = synd_ff;
      nxt_sec      = sec_ff;
      nxt_wcnt     = wcnt_ff;
      nxt_pwords   = page_len(rs_mode, psz);
      // Syndromes stand only with the sector end, hold them for the result
      nxt_hsyn     = sector_end ? ham_syndrome : hsyn_ff;
      nxt_rsyn     = sector_end ? rs_syndrome : rsyn_ff;
      nxt_st       = st_ff;
      nxt_cst      = 1'b0;
      nxt_irq      = mode_ff[ECCS_MODE_CORR_BIT]; // RULE_02
      if (wr_do && awa_ff == ECCS_OFF_MODE)
         nxt_mode = merge(mode_ff, wd_ff, ws_ff) & ECCS_MODE_MASK;
      // Clear first so a result landing in the same cycle still sets
      if (clr_par) begin
         nxt_par0 = ECCS_RST_VAL;
         nxt_par1 = ECCS_RST_VAL;
         nxt_synd = ECCS_RST_VAL;
         nxt_stat = ECCS_RST_VAL; // RULE_18
      end
      unique case (st_ff)
         ECCS_IDLE: begin
            if (flash_cmd && !mode_ff[ECCS_MODE_HALT_BIT]) begin // RULE_05
               nxt_st   = ECCS_RUN;
               nxt_stat = ECCS_RST_VAL; // RULE_18
               nxt_sec  = 3'h0;
               nxt_wcnt = 13'h0000;
            end
         end
         ECCS_RUN: begin
            if (flash_data_valid) begin
               // Word is 8 or 16 bits as strapped by the flash bus
               nxt_wcnt = wcnt_ff + 13'h0001; // RULE_09
            end
            if (chk_valid) begin
               if (rs_mode) begin
                  nxt_stat[sec_ff] = chk_err; // RULE_17
                  if (chk_err)
                     nxt_synd = rsyn_ff; // RULE_19
               end else begin
                  nxt_stat[4*sec_ff]   = chk_err; // RULE_11 RULE_16
                  nxt_stat[4*sec_ff+1] = chk_single; // RULE_14
                  nxt_stat[4*sec_ff+2] = chk_multi; // RULE_12
                  if (chk_single && typ == ECCS_TYPE_PAGE) begin
                     nxt_par0 = {16'h0000, hsyn_ff[15:4],
                                 hsyn_ff[3:0]}; // RULE_20
                     nxt_par1 = {16'h0000, hsyn_ff}; // RULE_15
                  end
               end
               // Page mode only ever fills sector 0
               if (typ != ECCS_TYPE_PAGE) // RULE_13 RULE_06
                  nxt_sec = sec_ff + 3'h1;
               if (wcnt_ff >= pwords_ff || typ == ECCS_TYPE_PAGE)
                  nxt_st = ECCS_CORR;
            end
         end
         ECCS_CORR: begin
            // Correction proceeds only if enabled
            nxt_cst = mode_ff[ECCS_MODE_CORR_BIT]; // RULE_02 RULE_03
            nxt_st  = ECCS_DONE;
         end
         ECCS_DONE: begin
            nxt_st = ECCS_IDLE;
         end
      endcase
      if (mode_ff[ECCS_MODE_HALT_BIT]) // RULE_04
         nxt_st = ECCS_IDLE;
      nxt_act = (nxt_st == ECCS_RUN);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin // RULE_21
         mode_ff     <= ECCS_RST_VAL;
         stat_ff     <= ECCS_RST_VAL;
         par0_ff     <= ECCS_RST_VAL;
         par1_ff     <= ECCS_RST_VAL;
         synd_ff     <= ECCS_RST_VAL;
         sec_ff      <= 3'h0;
         wcnt_ff     <= 13'h0000;
         pwords_ff   <= ECCS_PAGE_W0;
         hsyn_ff     <= 16'h0000;
         rsyn_ff     <= ECCS_RST_VAL;
         st_ff       <= ECCS_IDLE;
         act_ff      <= 1'b0;
         cst_ff      <= 1'b0;
         irq_ff      <= 1'b0;
      end else begin
         mode_ff     <= nxt_mode;
         stat_ff     <= nxt_stat;
         par0_ff     <= nxt_par0;
         par1_ff     <= nxt_par1;
         synd_ff     <= nxt_synd;
         sec_ff      <= nxt_sec;
         wcnt_ff     <= nxt_wcnt;
         pwords_ff   <= nxt_pwords;
         hsyn_ff     <= nxt_hsyn;
         rsyn_ff     <= nxt_rsyn;
         st_ff       <= nxt_st;
         act_ff      <= nxt_act;
         cst_ff      <= nxt_cst;
         irq_ff      <= nxt_irq;
      end
   end

   assign compute_active = act_ff;
   assign correct_start  = cst_ff;
   assign irq_permit     = irq_ff;
   assign page_words     = pwords_ff;
endmodule

// *** dv/eccs_ctrl_properties.sv ***
// Concurrent checks on the ports of the ECC control block
`timescale 1ns/1ps
module eccs_ctrl_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Flash watch and engine status
   input wire logic flash_cmd,
   input wire logic compute_active,
   input wire logic correct_start,
   input wire logic irq_permit
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==================================================
   // Write handshake steps
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      ##[1:2] s_axi_bvalid;
   endsequence
   // ==================================================
   // Properties
   a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
      else $error("write response missing");
   a_write_blocked: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   a_read_stall: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_run_cause: assert property (
      $rose(compute_active) |-> $past(flash_cmd))
      else $error("computation started without command");
   a_corr_permit: assert property (correct_start |-> irq_permit)
      else $error("correction started while disabled");
   a_corr_pulse: assert property (correct_start |=> !correct_start)
      else $error("correction start longer than one cycle");
   a_corr_after_run: assert property (
      correct_start |-> !compute_active)
      else $error("correction during syndrome step");
   a_permit_on_write: assert property (
      $changed(irq_permit) |->
         s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("permit changed without register write");
endmodule

// *** dv/eccs_flash_model.sv ***
// Behavioural flash side: commands, data words and sector ends
`timescale 1ns/1ps
module eccs_flash_model (
   // Clock
   input  wire logic   aclk,
   // Watched flash traffic
   output logic        flash_cmd,
   output logic        flash_wide,
   output logic        flash_data_valid,
   output logic [15:0] flash_data,
   output logic        sector_end,
   output logic [15:0] ham_syndrome,
   output logic [31:0] rs_syndrome
);
   initial begin
      flash_cmd = 1'b0;
      flash_wide = 1'b0;
      flash_data_valid = 1'b0;
      flash_data = 16'h0000;
      sector_end = 1'b0;
      ham_syndrome = 16'hffff;
      rs_syndrome = 32'hffff_ffff;
   end
   // One-cycle read or write command
   task automatic cmd();
      flash_cmd <= 1'b1;
      @(posedge aclk);
      flash_cmd <= 1'b0;
   endtask
   // Words with g idle cycles between them, then the sector end
   task automatic sector(input int n, input int g, input logic [15:0] h,
                         input logic [31:0] s);
      repeat (n) begin
         flash_data_valid <= 1'b1;
         flash_data <= flash_data + 16'h0001;
         @(posedge aclk);
         // Back-to-back words keep valid high rather than drop and raise it
         if (g > 0) begin
            flash_data_valid <= 1'b0;
            repeat (g) @(posedge aclk);
         end
      end
      if (g == 0)
         flash_data_valid <= 1'b0;
      sector_end <= 1'b1;
      ham_syndrome <= h;
      rs_syndrome <= s;
      @(posedge aclk);
      // Syndromes are stale outside the sector end
      sector_end <= 1'b0;
      ham_syndrome <= ~h;
      rs_syndrome <= ~s;
   endtask
endmodule

// *** dv/tb.sv ***
// Testbench of the ECC control, mode and status block
`timescale 1ns/1ps
module tb;
   import eccs_pkg::*;
   // ==================================================
   // Signals
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, flash_cmd, flash_wide, flash_data_valid;
   logic        sector_end, compute_active, correct_start, irq_permit;
   logic        s_axi_bready, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [31:0] rs_syndrome, rd;
   logic [15:0] flash_data, ham_syndrome;
   logic [12:0] page_words;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          errors, checks, cyc, n_corr;
   eccs_ctrl i_dut (.*);
   eccs_flash_model i_flash (.*);
   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (correct_start === 1'b1) n_corr <= n_corr + 1;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   // ==================================================
   // Bus and compare tasks
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic axi_wr(input logic [8:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= {23'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
   endtask
   task automatic axi_rd(input logic [8:0] a);
      s_axi_araddr <= {23'h0, a};
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic rd_chk(input logic [8:0] a, input logic [31:0] e,
                         input logic [1:0] r);
      axi_rd(a);
      chk("rdata", e, rd);
      chk("rresp", {30'h0, r}, {30'h0, rsp});
   endtask
   task automatic wr_chk(input logic [8:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      axi_wr(a, d);
      chk("bresp", {30'h0, r}, {30'h0, rsp});
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 64 && compute_active !== 1'b0; i++) @(posedge aclk);
      repeat (4) @(posedge aclk);
   endtask
   // ==================================================
   // Scenarios
   task automatic t_reset();
      chk("page_words", 32'h210, {19'h0, page_words});
      rd_chk(ECCS_OFF_MODE, 32'h0, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_STAT, 32'h0, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_PAR0, 32'h0, ECCS_RESP_OK);
   endtask
   task automatic t_map();
      logic [31:0] m, e;
      wr_chk(ECCS_OFF_MODE, 32'hffff_ffff, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_MODE, 32'h0000_0577, ECCS_RESP_OK);
      wr_chk(9'h1fc, 32'h0, ECCS_RESP_ERR);
      rd_chk(9'h1fc, 32'h0, ECCS_RESP_ERR);
      wr_chk(ECCS_OFF_STAT, 32'h1, ECCS_RESP_ERR);
      rd_chk(ECCS_OFF_CTRL, 32'h0, ECCS_RESP_OK);
      for (int c = 0; c < 12; c++) begin
         m = (c < 4) ? ((c % 3) << 4) | c : 32'h40 | (c - 4);
         e = (c < 4) ? 32'h210 << c : 32'h210 * (c - 3);
         axi_wr(ECCS_OFF_MODE, m | 32'h100);
         repeat (2) @(posedge aclk);
         chk("page_words", e, {19'h0, page_words});
      end
   endtask
   task automatic t_halt();
      axi_wr(ECCS_OFF_MODE, 32'h100);
      i_flash.cmd();
      repeat (3) @(posedge aclk);
      chk("compute_active", 32'h0, {31'h0, compute_active});
      axi_wr(ECCS_OFF_MODE, 32'h0);
      i_flash.cmd();
      @(posedge aclk);
      chk("compute_active", 32'h1, {31'h0, compute_active});
      i_flash.sector(10, 1, 16'h0ff0, 32'h0);
      wait_idle();
      rd_chk(ECCS_OFF_STAT, 32'h3, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_PAR0, 32'h0ff0, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_PAR1, 32'h0ff0, ECCS_RESP_OK);
      wr_chk(ECCS_OFF_CTRL, 32'h0, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_STAT, 32'h3, ECCS_RESP_OK);
      wr_chk(ECCS_OFF_CTRL, 32'h1, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_STAT, 32'h0, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_PAR0, 32'h0, ECCS_RESP_OK);
      chk("corr_starts", 32'h0, n_corr);
   endtask
   task automatic t_sect();
      axi_wr(ECCS_OFF_MODE, 32'h110);
      axi_wr(ECCS_OFF_MODE, 32'h010);
      i_flash.cmd();
      i_flash.sector(256, 0, 16'h0000, 32'h0);
      i_flash.sector(256, 0, 16'h0100, 32'h0);
      i_flash.sector(256, 0, 16'h0003, 32'h0);
      wait_idle();
      rd_chk(ECCS_OFF_STAT, 32'h530, ECCS_RESP_OK);
      chk("corr_starts", 32'h0, n_corr);
   endtask
   task automatic t_rs();
      axi_wr(ECCS_OFF_MODE, 32'h541);
      axi_wr(ECCS_OFF_MODE, 32'h441);
      i_flash.cmd();
      i_flash.sector(528, 0, 16'h0, 32'h0);
      i_flash.sector(528, 0, 16'h0, 32'h0001_0000);
      wait_idle();
      rd_chk(ECCS_OFF_STAT, 32'h2, ECCS_RESP_OK);
      rd_chk(ECCS_OFF_SYND, 32'h0001_0000, ECCS_RESP_OK);
      chk("corr_starts", 32'h1, n_corr);
      chk("irq_permit", 32'h1, {31'h0, irq_permit});
      i_flash.cmd();
      @(posedge aclk);
      rd_chk(ECCS_OFF_STAT, 32'h0, ECCS_RESP_OK);
      axi_wr(ECCS_OFF_MODE, 32'h100);
      repeat (2) @(posedge aclk);
      chk("compute_active", 32'h0, {31'h0, compute_active});
   endtask
   task automatic finish_test();
      if (errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      s_axi_awaddr = 32'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_araddr = 32'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_map();
      t_halt();
      t_sect();
      t_rs();
      finish_test();
   end
endmodule
bind eccs_ctrl eccs_ctrl_chk i_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .flash_cmd,
   .compute_active, .correct_start, .irq_permit);
